// ---- rtl/wakeup_pkg.sv ----
// Purpose: shared constants of the periodic wakeup timer
// Assumes: 125 MHz mclk, word-per-register Avalon-MM map
// Notes:   register index times four gives the byte address
package wakeup_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 32;
  localparam int          INDEX_W       = 10;
  localparam int          TRIM_W        = 6;
  localparam int          RATE_W        = 16;
  localparam int          COUNT_W       = RATE_W + 1;

  // register indices
  localparam logic [9:0]  CTRL_INDEX    = 10'h2F2;
  localparam logic [9:0]  TRIM_INDEX    = 10'h2F3;
  localparam logic [9:0]  RATE_INDEX    = 10'h2F4;
  localparam logic [9:0]  STATUS_INDEX  = 10'h2F8;
  localparam logic [9:0]  MASK_INDEX    = 10'h2F9;

  // control and trim field positions
  localparam int          CLK_SEL_BIT   = 7;
  localparam int          WAVE_SEL_BIT  = 4;
  localparam int          EXT_EN_BIT    = 3;
  localparam int          FEATURE_BIT   = 2;
  localparam int          IRQ_EN_BIT    = 1;
  localparam int          FLAG_BIT      = 0;
  localparam int          TRIM_LSB      = 2;

  // reset values
  localparam logic        CTRL_BIT_RESET = 1'b0;
  localparam logic [5:0]  TRIM_RESET    = 6'h00;
  localparam logic [15:0] RATE_RESET    = 16'h0000;

  // timing
  localparam int          CLK_PERIOD_NS = 8;
  localparam int          OSC_TICK_NS   = 100000;
  localparam int          OSC_TICK_CYCLES =
    (OSC_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          TRIM_UNIT_CYCLES = 8;

  typedef enum logic [1:0] {
    BUS_IDLE   = 2'b01,
    BUS_ANSWER = 2'b10
  } bus_state_type;

endpackage

// ---- rtl/wakeup_osc.sv ----
// Purpose: trimmed internal tick source, one tick per nominal 0.1 ms
// Assumes: run low holds the divider at its start
// Notes:   trim changes take effect on the running interval
`timescale 1ns/100ps
module wakeup_osc #(
  parameter int OSC_CYCLES = wakeup_pkg::OSC_TICK_CYCLES,
  parameter int TRIM_UNIT  = wakeup_pkg::TRIM_UNIT_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic                          run,
  input  wire logic [wakeup_pkg::TRIM_W-1:0] trim,
  output logic                               tick
);
  import wakeup_pkg::*;

  typedef struct packed {
    logic [COUNT_W-1:0] count;
    logic               tick;
  } osc_state_type;

  osc_state_type s;
  osc_state_type next_s;

  // upper trim bit lengthens, each lower bit shortens by half the last
  function automatic logic [COUNT_W-1:0] trimmed_limit(
    input logic [TRIM_W-1:0] t);
    int p;
    p = OSC_CYCLES + TRIM_UNIT * (32 * int'(t[5]) - 16 * int'(t[4])
        - 8 * int'(t[3]) - 4 * int'(t[2]) - 2 * int'(t[1])
        - int'(t[0]));
    if (p < 2) begin
      p = 2;
    end
    return COUNT_W'(p - 1);
  endfunction

  always_comb begin
    next_s      = s;
    next_s.tick = 1'b0;
    if (!run) begin
      next_s.count = '0;
    end else if (s.count >= trimmed_limit(trim)) begin
      next_s.count = '0;
      next_s.tick  = 1'b1;
    end else begin
      next_s.count = s.count + 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign tick = s.tick;

endmodule // wakeup_osc

// ---- rtl/periodic_wakeup_timer.sv ----
// Purpose: self-timed periodic wakeup timer with Avalon-MM registers
// Assumes: single 125 MHz clock, master holds requests per Avalon
// Notes:   one wait state per access, unmapped reads return zero
`timescale 1ns/100ps

//
// Overview of operation
// - clock select 0 internal oscillator, 1 bus
// - clock select writable only with feature off and left off
// - square wave at twice the timeout period
// - otherwise one-tick high pulse per period
// - pin driven only with output and feature enabled
// - feature enable starts and stops the timer
// - interrupt request while flag and enable set
// - flag sets whenever the period elapses
// - flag cleared by writing one, clear wins
// - six-bit trim held in bits seven to two
// - top trim bit lengthens, lower bits shorten
// - trim resets to zero or factory preset
// - period is two times rate plus two ticks
// - rate writable only with feature off
module periodic_wakeup_timer #(
  parameter int OSC_CYCLES = wakeup_pkg::OSC_TICK_CYCLES,
  parameter int TRIM_UNIT  = wakeup_pkg::TRIM_UNIT_CYCLES
) (
  input  wire logic                          mclk,
  input  wire logic                          rst_n,
  input  wire logic [wakeup_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                          avs_read,
  input  wire logic                          avs_write,
  input  wire logic [wakeup_pkg::DATA_W-1:0] avs_writedata,
  input  wire logic [3:0]                    avs_byteenable,
  output logic      [wakeup_pkg::DATA_W-1:0] avs_readdata,
  output logic                               avs_waitrequest,
  input  wire logic                          trim_preset_sel,
  input  wire logic [wakeup_pkg::TRIM_W-1:0] trim_preset,
  output logic                               wakeup_irq,
  output logic                               ext_wave_out,
  output logic                               ext_wave_oe
);
  import wakeup_pkg::*;

  typedef struct packed {
    bus_state_type      bus;
    logic [DATA_W-1:0]  rdata;
    logic               loaded;
    logic               clk_sel;
    logic               wave_sel;
    logic               ext_en;
    logic               feature;
    logic               irq_en;
    logic               flag;
    logic [TRIM_W-1:0]  trim;
    logic [RATE_W-1:0]  rate;
    logic [COUNT_W-1:0] count;
    logic               square;
    logic               pulse;
    logic               irq;
    logic               pin;
    logic               pin_oe;
    logic               preset_sel_meta;
    logic               preset_sel_sync;
    logic [TRIM_W-1:0]  preset_meta;
    logic [TRIM_W-1:0]  preset_sync;
    logic [1:0]         settle;
  } timer_state_type;

  timer_state_type s;
  timer_state_type next_s;

  logic osc_tick;
  logic osc_run;
  logic tick;
  logic timeout;
  logic clear_flag;
  logic write_now;
  logic [7:0] wbyte;

  // word decode of a byte address against a register index
  function automatic logic hit(input logic [ADDR_W-1:0] addr,
                               input logic [INDEX_W-1:0] index);
    return addr[ADDR_W-1:2] == index;
  endfunction

  function automatic logic [7:0] ctrl_byte(input timer_state_type t);
    logic [7:0] b;
    b               = 8'h00;
    b[CLK_SEL_BIT]  = t.clk_sel;
    b[WAVE_SEL_BIT] = t.wave_sel;
    b[EXT_EN_BIT]   = t.ext_en;
    b[FEATURE_BIT]  = t.feature;
    b[IRQ_EN_BIT]   = t.irq_en;
    b[FLAG_BIT]     = t.flag;
    return b;
  endfunction

  function automatic logic [DATA_W-1:0] read_word(
    input timer_state_type t, input logic [ADDR_W-1:0] addr);
    logic [DATA_W-1:0] w;
    w = '0;
    if (hit(addr, CTRL_INDEX)) begin
      w[7:0] = ctrl_byte(t);
    end else if (hit(addr, TRIM_INDEX)) begin
      w[7:TRIM_LSB] = t.trim;
    end else if (hit(addr, RATE_INDEX)) begin
      w[RATE_W-1:0] = t.rate;
    end else if (hit(addr, STATUS_INDEX)) begin
      w[FLAG_BIT] = t.flag;
    end else if (hit(addr, MASK_INDEX)) begin
      w[FLAG_BIT] = t.irq_en;
    end
    return w;
  endfunction

  // internal oscillator only runs while it is the chosen source
  assign osc_run = s.feature & ~s.clk_sel;

  wakeup_osc #(
    .OSC_CYCLES (OSC_CYCLES),
    .TRIM_UNIT  (TRIM_UNIT)
  ) osc (
    .mclk  (mclk),
    .rst_n (rst_n),
    .run   (osc_run),
    .trim  (s.trim),
    .tick  (osc_tick)
  );

  assign tick      = s.clk_sel ? 1'b1 : osc_tick;
  assign write_now = (s.bus == BUS_ANSWER) & avs_write;
  assign wbyte     = avs_writedata[7:0];

  // end of the full period, the counter sits at 2*(rate+1)-1
  assign timeout = s.feature & tick
                   & (s.count >= {s.rate, 1'b1});

  always_comb begin
    clear_flag = 1'b0;
    if (write_now && avs_byteenable[0] && wbyte[FLAG_BIT]) begin
      if (hit(avs_address, CTRL_INDEX)
          || hit(avs_address, STATUS_INDEX)) begin
        clear_flag = 1'b1;
      end
    end
  end

  always_comb begin
    next_s = s;

    // bus handshake: one wait state, data and write on the answer
    case (s.bus)
      BUS_IDLE: begin
        if (avs_read || avs_write) begin
          next_s.bus = BUS_ANSWER;
        end
        if (avs_read) begin
          next_s.rdata = read_word(s, avs_address);
        end
      end
      BUS_ANSWER: begin
        next_s.bus = BUS_IDLE;
      end
      default: begin
        next_s.bus = BUS_IDLE;
      end
    endcase

    // straps pass two flip-flops before the preset load reads them
    next_s.preset_sel_meta = trim_preset_sel;
    next_s.preset_sel_sync = s.preset_sel_meta;
    next_s.preset_meta     = trim_preset;
    next_s.preset_sync     = s.preset_meta;

    // trim preset captured once the strap pipeline has filled
    if (!s.loaded) begin
      if (!s.settle[1]) begin
        next_s.settle = s.settle + 2'h1;
      end else begin
        next_s.loaded = 1'b1;
        next_s.trim   = s.preset_sel_sync ? s.preset_sync
                                          : TRIM_RESET;
      end
    end

    // register writes
    if (write_now && avs_byteenable[0]) begin
      if (hit(avs_address, CTRL_INDEX)) begin
        if (!s.feature && !wbyte[FEATURE_BIT]) begin
          next_s.clk_sel = wbyte[CLK_SEL_BIT];
        end
        next_s.wave_sel = wbyte[WAVE_SEL_BIT];
        next_s.ext_en   = wbyte[EXT_EN_BIT];
        next_s.feature  = wbyte[FEATURE_BIT];
        next_s.irq_en   = wbyte[IRQ_EN_BIT];
      end
      if (hit(avs_address, TRIM_INDEX)) begin
        next_s.trim   = wbyte[7:TRIM_LSB];
        next_s.loaded = 1'b1;
      end
      if (hit(avs_address, MASK_INDEX)) begin
        next_s.irq_en = wbyte[FLAG_BIT];
      end
    end
    if (write_now && hit(avs_address, RATE_INDEX) && !s.feature) begin
      if (avs_byteenable[0]) begin
        next_s.rate[7:0] = avs_writedata[7:0];
      end
      if (avs_byteenable[1]) begin
        next_s.rate[15:8] = avs_writedata[15:8];
      end
    end

    // period counter
    if (!s.feature) begin
      next_s.count  = '0;
      next_s.square = 1'b0;
      next_s.pulse  = 1'b0;
    end else if (timeout) begin
      next_s.count  = '0;
      next_s.square = ~s.square;
      next_s.pulse  = 1'b1;
    end else if (tick) begin
      next_s.count = s.count + 1'b1;
      next_s.pulse = 1'b0;
    end

    // sticky flag, a clear in the same cycle beats the timeout
    next_s.flag = (s.flag | timeout) & ~clear_flag;

    // registered outputs follow the next state without lag
    next_s.irq    = next_s.flag & next_s.irq_en;
    next_s.pin_oe = next_s.ext_en & next_s.feature;
    next_s.pin    = next_s.pin_oe
                    & (next_s.wave_sel ? next_s.square
                                       : next_s.pulse);
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.bus      <= BUS_IDLE;
      s.clk_sel  <= CTRL_BIT_RESET;
      s.wave_sel <= CTRL_BIT_RESET;
      s.ext_en   <= CTRL_BIT_RESET;
      s.feature  <= CTRL_BIT_RESET;
      s.irq_en   <= CTRL_BIT_RESET;
      s.flag     <= CTRL_BIT_RESET;
      s.trim     <= TRIM_RESET;
      s.rate     <= RATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  assign avs_waitrequest = (avs_read | avs_write)
                           & (s.bus != BUS_ANSWER);
  assign avs_readdata    = s.rdata;
  assign wakeup_irq      = s.irq;
  assign ext_wave_out    = s.pin;
  assign ext_wave_oe     = s.pin_oe;

endmodule // periodic_wakeup_timer

// ---- testbench/wakeup_chk.sv ----
// Purpose: port assertions of the wakeup timer
// Assumes: one clock, async active-low reset
// Notes:   bound to the top module below
`timescale 1ns/100ps
module wakeup_chk (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic [11:0] avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        wakeup_irq,
  input wire logic        ext_wave_out,
  input wire logic        ext_wave_oe
);
  wire rd = avs_read && !avs_waitrequest;
  wire wr = avs_write && !avs_waitrequest && avs_byteenable[0];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  pin_gate_a: assert property (!ext_wave_oe |-> !ext_wave_out)
    else $error("pin active while undriven");
  wait_first_a: assert property ($rose(avs_read || avs_write)
    |-> avs_waitrequest) else $error("no wait cycle");
  wait_once_a: assert property ((avs_read || avs_write) && avs_waitrequest
    |=> !avs_waitrequest) else $error("wait longer than one cycle");
  hole_zero_a: assert property (rd && avs_address == 12'hFFC
    |-> avs_readdata == 32'h0) else $error("unmapped read not zero");
  ctrl_spare_a: assert property (rd && avs_address == 12'hBC8
    |-> avs_readdata[31:8] == 24'h0 && avs_readdata[6:5] == 2'b00)
    else $error("control spare bits set");
  trim_low_a: assert property (rd && avs_address == 12'hBCC
    |-> avs_readdata[31:8] == 24'h0 && avs_readdata[1:0] == 2'b00)
    else $error("trim spare bits set");
  flag_clear_a: assert property (wr && avs_writedata[0] &&
    (avs_address == 12'hBE0 || avs_address == 12'hBC8) |=> !wakeup_irq)
    else $error("irq after flag clear");
  mask_off_a: assert property (wr &&
    ((avs_address == 12'hBE4 && !avs_writedata[0]) ||
     (avs_address == 12'hBC8 && !avs_writedata[1])) |=> !wakeup_irq)
    else $error("irq while masked");
endmodule // wakeup_chk
bind periodic_wakeup_timer wakeup_chk wakeup_chk_inst (.mclk, .rst_n,
  .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_byteenable,
  .avs_readdata, .avs_waitrequest, .wakeup_irq, .ext_wave_out,
  .ext_wave_oe);

// ---- testbench/wave_probe.sv ----
// Purpose: pin-side observer timing the wakeup waveform
// Assumes: one sample per mclk rising edge
// Notes:   last rise-to-rise span and last high time
`timescale 1ns/100ps
module wave_probe (
  input  wire logic mclk,
  input  wire logic ext_wave_out,
  output int        period,
  output int        high
);
  int   span = 0;
  int   run_high = 0;
  logic last = 1'b0;
  always @(posedge mclk) begin
    span <= ext_wave_out && !last ? 1 : span + 1;
    run_high <= ext_wave_out ? run_high + 1 : 0;
    if (ext_wave_out && !last)
      period <= span;
    if (!ext_wave_out && last)
      high <= run_high;
    last <= ext_wave_out;
  end
endmodule // wave_probe

// ---- testbench/periodic_wakeup_timer_tb_top.sv ----
// Purpose: self-checking bench of the wakeup timer
// Assumes: short oscillator count, unit trim step
// Notes:   probe measures the pin waveform
`timescale 1ns/100ps
module periodic_wakeup_timer_tb_top;
  import wakeup_pkg::*;
  localparam int         OSC = 20;
  localparam logic [5:0] TV [3] = '{6'h00, 6'h20, 6'h1F};
  logic        mclk = 1'b0;
  logic        rst_n = 1'b0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [11:0] avs_address = 12'h000;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'hF;
  logic [31:0] avs_readdata, rdata;
  logic [31:0] seed = 32'h81B12FC3;
  logic        avs_waitrequest, wakeup_irq, ext_wave_out, ext_wave_oe;
  int          fails = 0, tests_run = 0, period, high, r, t;
  always #4 mclk = ~mclk;
  periodic_wakeup_timer #(.OSC_CYCLES(OSC), .TRIM_UNIT(1))
    periodic_wakeup_timer_inst (.mclk, .rst_n, .avs_address, .avs_read,
    .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
    .avs_waitrequest, .trim_preset_sel(1'b1), .trim_preset(6'h2A),
    .wakeup_irq, .ext_wave_out, .ext_wave_oe);
  wave_probe wave_probe_inst (.mclk, .ext_wave_out, .period, .high);
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic int osc_per(logic [5:0] v);
    int p;
    p = OSC + 32*v[5] - 16*v[4] - 8*v[3] - 4*v[2] - 2*v[1] - v[0];
    return 2 * (p < 2 ? 2 : p);
  endfunction
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic bus(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge mclk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= d;
    do @(posedge mclk); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic rchk(string nm, logic [11:0] a, logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, rdata, e);
  endtask
  task automatic idle(int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge mclk);
    fails++;
    test_done;
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    rchk("ctrl", 12'hBC8, 32'h0);
    rchk("trim", 12'hBCC, 32'hA8);
    bus(1'b1, 12'hFFC, 32'hFF);
    rchk("hole", 12'hFFC, 32'h0);
    bus(1'b1, 12'hBC8, 32'h84);
    rchk("ctrl", 12'hBC8, 32'h04);
    bus(1'b1, 12'hBD0, rnd());
    rchk("rate", 12'hBD0, 32'h0);
    bus(1'b1, 12'hBC8, 32'h00);
    bus(1'b1, 12'hBC8, 32'h80);
    rchk("ctrl", 12'hBC8, 32'h80);
    repeat (3) begin
      r = int'(rnd() & 7);
      bus(1'b1, 12'hBC8, 32'h80);
      bus(1'b1, 12'hBD0, 32'(r));
      rchk("rate", 12'hBD0, 32'(r));
      bus(1'b1, 12'hBC8, 32'h8C);
      idle(8 * r + 20);
      chk("pulse period", period, 2 * r + 2);
      chk("pulse width", high, 1);
      chk("oe", 32'(ext_wave_oe), 1);
      bus(1'b1, 12'hBC8, 32'h80);
      bus(1'b1, 12'hBC8, 32'h9C);
      idle(16 * r + 40);
      chk("square period", period, 4 * r + 4);
      chk("square high", high, 2 * r + 2);
    end
    bus(1'b1, 12'hBC8, 32'h94);
    idle(2);
    chk("pin", 32'({ext_wave_oe, ext_wave_out}), 0);
    chk("irq", 32'(wakeup_irq), 0);
    rchk("ctrl", 12'hBC8, 32'h95);
    bus(1'b1, 12'hBE4, 32'h1);
    idle(2);
    chk("irq", 32'(wakeup_irq), 1);
    bus(1'b1, 12'hBC8, 32'h82);
    bus(1'b1, 12'hBE0, 32'h0);
    rchk("ctrl", 12'hBC8, 32'h83);
    bus(1'b1, 12'hBE0, 32'h1);
    rchk("ctrl", 12'hBC8, 32'h82);
    chk("irq", 32'(wakeup_irq), 0);
    bus(1'b1, 12'hBE4, 32'h0);
    bus(1'b1, 12'hBC8, 32'h00);
    bus(1'b1, 12'hBD0, 32'h0);
    for (int i = 0; i < 4; i++) begin
      t = i < 3 ? int'(TV[i]) : int'(rnd() & 63);
      bus(1'b1, 12'hBCC, 32'(t << 2));
      rchk("trim", 12'hBCC, 32'(t << 2));
      bus(1'b1, 12'hBC8, 32'h0C);
      idle(4 * osc_per(6'(t)) + 20);
      chk("osc period", period, osc_per(6'(t)));
      bus(1'b1, 12'hBC8, 32'h00);
    end
    rchk("status", 12'hBE0, 32'h1);
    bus(1'b1, 12'hBC8, 32'h01);
    rchk("ctrl", 12'hBC8, 32'h0);
    avs_byteenable <= 4'h1;
    bus(1'b1, 12'hBD0, 32'hABCD);
    avs_byteenable <= 4'hF;
    rchk("rate lane", 12'hBD0, 32'hCD);
    test_done;
  end
endmodule // periodic_wakeup_timer_tb_top
